// ===== hdl/cell_discharge_control.v
//Contract
// - Permitted bit set leaves switches untouched.
// - Permitted clear turns off converting neighbours.
// - Outputs k, k+6 off periods k-1..k+1.
// - Forced-off wins over discharge enable.
// - Enabled output stays on otherwise.
// - Thermal detection armed except while asleep.
// - Over-temperature resets configuration, switches off.
// - Over-temperature sets thermal-shutdown flag.
// - Status group B read clears flag.
// - Clear-status command acts on flag.
// - Switch pins are pulled-up digital outputs.
`timescale 1ns/1ps
`default_nettype none
`include "discharge_consts.vh"

module cell_discharge_control #(
  parameter CELLS = 12,
  parameter CNT_W = 16,
  parameter PERIOD_CYCLES = `PERIOD_NS / `CLK_NS
) (
  // Clock and reset.
  input wire i_mclk,
  input wire i_rstn,
  // Register port.
  input wire [`ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // Die temperature detector, high above threshold.
  input wire i_overtemp,
  // Discharge switch pins: drive low pulls gate, released pin floats to pull-up.
  output wire [CELLS-1:0] o_discharge_out,
  output wire [CELLS-1:0] o_discharge_oe,
  // Status and interrupt.
  output wire o_converting,
  output wire o_irq
);
  localparam [CNT_W-1:0] PCYC = PERIOD_CYCLES[CNT_W-1:0];
  // Sequencer states, one-hot.
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CELLS-1:0] cell_discharge_enable_reg;
  reg sleep_reg;
  reg discharge_permitted_reg;
  reg [5:0] period_reg;
  reg calib_half_reg;
  reg thermal_shutdown_flag_reg;
  reg [`IRQ_W-1:0] irq_stat_reg;
  reg [`IRQ_W-1:0] irq_mask_reg;
  reg trip_prev_reg;
  wire tick;
  wire [CELLS-1:0] force_off;
  wire trip;
  wire trip_rise;
  wire conv_start;
  wire clear_stat;
  wire rd_status_b;
  wire last_period;
  wire conv_done;

  assign conv_start = i_wr && (i_addr == `ADDR_CMD) && i_wdata[`CMD_CONVERT_BIT];
  assign clear_stat = i_wr && (i_addr == `ADDR_CMD) && i_wdata[`CMD_CLEAR_STAT_BIT];
  assign rd_status_b = i_rd && (i_addr == `ADDR_STATUS_B);
  assign trip = i_overtemp && !sleep_reg;
  assign trip_rise = trip && !trip_prev_reg;
  assign last_period = period_reg[5];
  assign conv_done = (state_reg == ST_CONV) && tick && last_period && calib_half_reg;
  assign o_converting = (state_reg == ST_CONV);

  period_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_run(o_converting),
    .i_cycles(PCYC),
    .o_tick(tick)
  );

  discharge_mask #(
    .CELLS(CELLS)
  ) u_mask (
    .i_period_onehot(period_reg),
    .i_forcing(o_converting && !discharge_permitted_reg),
    .o_force_off(force_off)
  );

  // Sequencer next state; the conversion runs all twelve periods unless a trip ends it early.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (conv_start && !trip) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_done || trip) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers: period walks one-hot through six, then again for calibration.
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      period_reg <= 6'h01;
      calib_half_reg <= 1'b0;
      discharge_permitted_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && state_next == ST_CONV) begin
        period_reg <= 6'h01;
        calib_half_reg <= 1'b0;
        discharge_permitted_reg <= i_wdata[`CMD_PERMIT_BIT];
      end else if (o_converting && tick) begin
        period_reg <= {period_reg[4:0], period_reg[5]};
        if (last_period) begin
          calib_half_reg <= 1'b1;
        end
      end
    end
  end

  // Configuration; an over-temperature trip returns it to defaults.
  always @(posedge i_mclk) begin
    if (!i_rstn || trip) begin
      cell_discharge_enable_reg <= `CELL_EN_RESET;
      sleep_reg <= 1'b0;
      irq_mask_reg <= `IRQ_MASK_RESET;
    end else if (i_wr) begin
      if (i_addr == `ADDR_CELL_EN) begin
        cell_discharge_enable_reg <= i_wdata[CELLS-1:0];
      end
      if (i_addr == `ADDR_CTRL) begin
        sleep_reg <= i_wdata[`CTRL_SLEEP_BIT];
      end
      if (i_addr == `ADDR_IRQ_MASK) begin
        irq_mask_reg <= i_wdata[`IRQ_W-1:0];
      end
    end
  end

  // Thermal flag: a trip beats any clear in the same cycle, and holds after cooling.
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      thermal_shutdown_flag_reg <= 1'b0;
      trip_prev_reg <= 1'b0;
    end else begin
      trip_prev_reg <= trip;
      if (trip) begin
        thermal_shutdown_flag_reg <= 1'b1;
      end else if (rd_status_b || clear_stat) begin
        thermal_shutdown_flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt status: sticky, write one to clear, a new event wins over the clear.
  always @(posedge i_mclk) begin
    if (!i_rstn) begin
      irq_stat_reg <= {`IRQ_W{1'b0}};
    end else begin
      if (i_wr && i_addr == `ADDR_IRQ_STAT) begin
        irq_stat_reg <= irq_stat_reg & ~i_wdata[`IRQ_W-1:0] |
          {conv_done, trip_rise};
      end else begin
        irq_stat_reg <= irq_stat_reg | {conv_done, trip_rise};
      end
    end
  end

  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  // Read data stand in the cycle after the strobe only; unmapped reads give zero.
  always @(posedge i_mclk) begin
    if (!i_rstn || !i_rd) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      case (i_addr)
        `ADDR_CTRL: o_rdata <= {31'h0, sleep_reg};
        `ADDR_CELL_EN: o_rdata <= {{(32-CELLS){1'b0}}, cell_discharge_enable_reg};
        `ADDR_STATUS_B: o_rdata <= {31'h0, thermal_shutdown_flag_reg};
        `ADDR_IRQ_STAT: o_rdata <= {30'h0, irq_stat_reg};
        `ADDR_IRQ_MASK: o_rdata <= {30'h0, irq_mask_reg};
        `ADDR_PHASE: o_rdata <= {23'h0, calib_half_reg, discharge_permitted_reg,
          o_converting, period_reg};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Switch drive: enabled and not forced off pulls low to turn on the switch.
  // Released pins go to the internal pull-up, which keeps the external gate off.
  assign o_discharge_oe = cell_discharge_enable_reg & ~force_off;
  assign o_discharge_out = {CELLS{1'b0}};
endmodule // cell_discharge_control
`default_nettype wire

// ===== hdl/discharge_mask.v
`timescale 1ns/1ps
`default_nettype none
`include "discharge_consts.vh"

module discharge_mask #(
  parameter CELLS = 12
) (
  // Current period, one-hot over six cell pairs.
  input wire [5:0] i_period_onehot,
  input wire i_forcing,
  // Per-cell forced-off mask.
  output wire [CELLS-1:0] o_force_off
);
  // Output k and k+6 are off in periods k-1, k, k+1, wrapping over six.
  genvar k;
  generate
    for (k = 0; k < CELLS; k = k + 1) begin : g_cell
      localparam integer P = k % 6;
      localparam integer PM = (P + 5) % 6;
      localparam integer PP = (P + 1) % 6;
      assign o_force_off[k] = i_forcing &&
        (i_period_onehot[PM] || i_period_onehot[P] || i_period_onehot[PP]);
    end
  endgenerate
endmodule // discharge_mask
`default_nettype wire

// ===== hdl/period_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "discharge_consts.vh"

module period_timer #(
  parameter CNT_W = 16
) (
  // Clock and reset.
  input wire i_mclk,
  input wire i_rstn,
  // Control.
  input wire i_run,
  input wire [CNT_W-1:0] i_cycles,
  // Period end pulse.
  output wire o_tick
);
  reg [CNT_W-1:0] cnt_reg;

  // Counts up the cycles of one conversion period; restarts when idle.
  always @(posedge i_mclk) begin
    if (!i_rstn || !i_run || o_tick) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else begin
      cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign o_tick = i_run && (cnt_reg == i_cycles - {{(CNT_W-1){1'b0}}, 1'b1});
endmodule // period_timer
`default_nettype wire

// ===== include/discharge_consts.vh
`ifndef DISCHARGE_CONSTS_VH
`define DISCHARGE_CONSTS_VH

// Register addresses on the plain register port.
`define ADDR_W 4
`define ADDR_CTRL 4'h0
`define ADDR_CELL_EN 4'h1
`define ADDR_STATUS_B 4'h2
`define ADDR_CMD 4'h3
`define ADDR_IRQ_STAT 4'h4
`define ADDR_IRQ_MASK 4'h5
`define ADDR_PHASE 4'h6

// Command register bits.
`define CMD_CONVERT_BIT 0
`define CMD_PERMIT_BIT 1
`define CMD_CLEAR_STAT_BIT 2

// Control register bits.
`define CTRL_SLEEP_BIT 0

// Status group B bit position of the thermal flag.
`define STAT_THERMAL_SHUTDOWN_FLAG_BIT 0

// Interrupt status bits.
`define IRQ_THERMAL_SHUTDOWN_FLAG_BIT 0
`define IRQ_DONE_BIT 1
`define IRQ_W 2

// Reset values.
`define CELL_EN_RESET 12'h000
`define IRQ_MASK_RESET 2'h0

// Conversion sequencing: six measure periods then six calibrate periods.
`define PERIODS_PER_HALF 3'h6
`define PERIOD_IDX_LAST 3'h5
`define PERIOD_NS 1000
`define CLK_NS 5

`endif

// ===== sim/cell_discharge_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cell_discharge_control_tb_top;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_overtemp = 1'b0;
  wire logic [31:0] o_rdata;
  wire logic [11:0] o_discharge_out, o_discharge_oe, pin;
  wire logic o_converting, o_irq;
  int bad_count = 0;
  int checks = 0;
  // Short periods keep the twelve-period conversion to 48 cycles.
  always #2.5 i_mclk = ~i_mclk;
  cell_discharge_control #(.PERIOD_CYCLES(4)) u_dut (.i_mclk, .i_rstn, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_overtemp, .o_discharge_out, .o_discharge_oe, .o_converting,
    .o_irq);
  gate_pullup_model u_gate (.i_oe(o_discharge_oe), .i_drive(o_discharge_out), .o_pin(pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rdc(input logic [3:0] a, input logic [31:0] want);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 check(o_rdata, want);
  endtask
  task automatic heat;
    @(posedge i_mclk);
    i_overtemp <= 1'b1;
    @(posedge i_mclk);
    i_overtemp <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // The phase register shows period one of the measure half after reset.
  task automatic reset_scenario;
    for (int a = 0; a < 8; a++) begin
      rdc(a[3:0], (a == 6) ? 32'h1 : 32'h0);
    end
  endtask
  task automatic conv_scenario;
    wr(4'h1, 32'hfff);
    wr(4'h5, 32'h2);
    wr(4'h3, 32'h1);
    settle(1);
    check(o_discharge_oe, 12'h71c);
    check(pin, 12'h8e3);
    settle(12);
    check(o_discharge_oe, 12'h8e3);
    settle(12);
    check(o_discharge_oe, 12'h71c);
    rdc(4'h6, 32'h141);
    settle(30);
    check(o_irq, 1'b1);
    rdc(4'h4, 32'h2);
    wr(4'h4, 32'h2);
    settle(1);
    check(o_irq, 1'b0);
    wr(4'h3, 32'h3);
    settle(1);
    check(o_discharge_oe, 12'hfff);
    settle(50);
  endtask
  // The permitted conversion leaves its done bit pending, so the trip must drop o_irq.
  task automatic thermal_scenario;
    wr(4'h0, 32'h1);
    heat();
    settle(1);
    check(o_discharge_oe, 12'hfff);
    rdc(4'h2, 32'h0);
    wr(4'h0, 32'h0);
    wr(4'h3, 32'h1);
    settle(5);
    check({o_irq, o_converting}, 2'h3);
    heat();
    settle(1);
    check({o_irq, o_converting, o_discharge_oe}, 14'h0);
    rdc(4'h2, 32'h1);
    rdc(4'h2, 32'h0);
    rdc(4'h1, 32'h0);
    rdc(4'h5, 32'h0);
    rdc(4'h4, 32'h3);
    heat();
    wr(4'h3, 32'h4);
    rdc(4'h2, 32'h0);
  endtask
  // Host self-test of the switches: a baseline with all off, then each pair k, k+6 alone.
  task automatic balance_scenario;
    wr(4'h1, 32'h0);
    wr(4'h3, 32'h1);
    settle(10);
    check(o_discharge_oe, 12'h000);
    settle(40);
    check(o_converting, 1'b0);
    for (int k = 0; k < 6; k++) begin
      wr(4'h1, 32'h41 << k);
      wr(4'h3, 32'h3);
      settle(20);
      check(o_discharge_oe, 32'h41 << k);
      settle(30);
      check(o_converting, 1'b0);
      wr(4'h1, 32'h0);
      rdc(4'h1, 32'h0);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // The whole sequence takes under a thousand cycles; this cuts off a hang.
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rstn <= 1'b1;
    reset_scenario();
    conv_scenario();
    thermal_scenario();
    balance_scenario();
    complete_run();
  end
endmodule // cell_discharge_control_tb_top
`default_nettype wire

// ===== sim/discharge_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module discharge_monitor #(parameter PERIOD_CYCLES = 4) (
  // Clock, reset and register port.
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Pins and status.
  input wire logic i_overtemp,
  input wire logic [11:0] o_discharge_out,
  input wire logic [11:0] o_discharge_oe,
  input wire logic o_converting,
  input wire logic o_irq
);
  logic sleep_reg, perm_reg;
  logic [11:0] en_reg, exp_oe;
  logic [15:0] cnt_reg;
  logic [5:0] hit, frc;
  wire logic trip = i_overtemp && !sleep_reg;
  // A start is refused by a live trip or a conversion in progress; a hot die while asleep does not block it.
  wire logic start = i_wr && i_addr == 4'h3 && i_wdata[0] && !o_converting && !trip;
  // Shadow configuration from bus traffic; a trip wins over a write in the same cycle.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || trip) begin
      sleep_reg <= 1'b0;
      en_reg <= 12'h000;
    end else if (i_wr && i_addr == 4'h0) begin
      sleep_reg <= i_wdata[0];
    end else if (i_wr && i_addr == 4'h1) begin
      en_reg <= i_wdata[11:0];
    end
    perm_reg <= start ? i_wdata[1] : perm_reg;
    cnt_reg <= o_converting ? cnt_reg + 16'h1 : 16'h0;
  end
  // Period k forces pairs k-1, k and k+1, wrapping over six periods.
  always_comb begin
    hit = 6'h0;
    hit[(cnt_reg / PERIOD_CYCLES) % 6] = 1'b1;
    frc = hit | {hit[0], hit[5:1]} | {hit[4:0], hit[5]};
    exp_oe = en_reg & ~((o_converting && !perm_reg) ? {frc, frc} : 12'h000);
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  sequence conv_req;
    start;
  endsequence
  pin_pattern_a: assert property (o_discharge_oe == exp_oe)
    else $error("discharge pattern wrong");
  permit_hold_a: assert property (o_converting && perm_reg && $past(o_converting)
    && !$past(i_wr) |-> $stable(o_discharge_oe)) else $error("permit pins moved");
  out_low_a: assert property (o_discharge_out == 12'h000) else $error("pin drive high");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside slot");
  conv_start_a: assert property (conv_req |=> o_converting) else $error("no conversion");
  conv_len_a: assert property ($fell(o_converting) |-> cnt_reg == 12 * PERIOD_CYCLES
    || $past(i_overtemp)) else $error("conversion length wrong");
  trip_off_a: assert property (trip |=> o_discharge_oe == 12'h000 && !o_converting)
    else $error("trip left switches on");
  trip_irq_a: assert property (trip |=> !o_irq) else $error("mask not reset by trip");
  sleep_arm_a: assert property (i_overtemp && sleep_reg && !o_converting && !i_wr
    |=> $stable(o_discharge_oe)) else $error("trip while asleep");
endmodule // discharge_monitor
bind cell_discharge_control discharge_monitor #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_mon (
  .i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_overtemp,
  .o_discharge_out, .o_discharge_oe, .o_converting, .o_irq);
`default_nettype wire

// ===== sim/gate_pullup_model.sv
`timescale 1ns/1ps
`default_nettype none
module gate_pullup_model (
  // Pin drive from the block.
  input wire logic [11:0] i_oe,
  input wire logic [11:0] i_drive,
  // Level seen at the external switch gate.
  output logic [11:0] o_pin
);
  // A released pin floats up to the pull-up, never to the last driven level.
  assign o_pin = (i_oe & i_drive) | ~i_oe;
endmodule // gate_pullup_model
`default_nettype wire
